// file: rtl/sff_top.sv
// Queue flags, data byte port and slave shifter of the serial unit
`timescale 1ns/10ps
`default_nettype none
module sff_top
    import sff_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire sff_bus_req_t bus_req,
    output logic [7:0] rd_data,
    input wire logic link_sck,
    input wire logic link_mosi,
    input wire logic link_sel_n,
    output logic link_miso_out,
    output logic link_miso_oe,
    output logic tx_empty_flag,
    output logic rx_full_flag,
    output logic queue_enable
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    wire logic [2:0] pin_raw = {link_sel_n, link_mosi, link_sck};
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic sck_prev;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            always_ff @(posedge mclk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    pin_meta[gi] <= (gi == 2);
                    pin_sync[gi] <= (gi == 2);
                end
                else
                begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    wire logic sck_s = pin_sync[0];
    wire logic mosi_s = pin_sync[1];
    wire logic sel_n_s = pin_sync[2];
    wire logic sck_rise = sck_s & ~sck_prev & ~sel_n_s;
    wire logic sck_fall = ~sck_s & sck_prev & ~sel_n_s;

    ////////////////////////////////////////////////////////////////////////////
    // Control registers and mode change detection

    logic module_enable;
    logic width_select;
    logic rx_mark;
    logic tx_mark;
    sff_status_t status;

    wire logic wr_ctrl = bus_req.wr && bus_req.addr == SFF_OFF_CTRL;
    wire logic wr_c3 = bus_req.wr && bus_req.addr == SFF_OFF_C3;
    wire logic wr_dh = bus_req.wr && bus_req.addr == SFF_OFF_DH;
    wire logic wr_dl = bus_req.wr && bus_req.addr == SFF_OFF_DL;
    wire logic rd_status = bus_req.rd && bus_req.addr == SFF_OFF_STATUS;
    wire logic rd_dh = bus_req.rd && bus_req.addr == SFF_OFF_DH;
    wire logic rd_dl = bus_req.rd && bus_req.addr == SFF_OFF_DL;
    wire logic rd_ctrl = bus_req.rd && bus_req.addr == SFF_OFF_CTRL;
    wire logic rd_c3 = bus_req.rd && bus_req.addr == SFF_OFF_C3;

    wire logic mode_change = (wr_ctrl
        && (bus_req.wdata[SFF_CTRL_ENABLE_BIT] != module_enable
        || bus_req.wdata[SFF_CTRL_WIDTH_BIT] != width_select))
        || (wr_c3 && bus_req.wdata[SFF_C3_QUEUE_BIT] != queue_enable);

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            module_enable <= SFF_CTRL_RESET[SFF_CTRL_ENABLE_BIT];
            width_select <= SFF_CTRL_RESET[SFF_CTRL_WIDTH_BIT];
            queue_enable <= SFF_C3_RESET[SFF_C3_QUEUE_BIT];
            rx_mark <= SFF_C3_RESET[SFF_C3_RX_MARK_BIT];
            tx_mark <= SFF_C3_RESET[SFF_C3_TX_MARK_BIT];
        end
        else
        begin
            if (wr_ctrl)
            begin
                module_enable <= bus_req.wdata[SFF_CTRL_ENABLE_BIT];
                width_select <= bus_req.wdata[SFF_CTRL_WIDTH_BIT];
            end
            if (wr_c3)
            begin
                queue_enable <= bus_req.wdata[SFF_C3_QUEUE_BIT];
                rx_mark <= bus_req.wdata[SFF_C3_RX_MARK_BIT];
                tx_mark <= bus_req.wdata[SFF_C3_TX_MARK_BIT];
            end
        end
    end

    // Bytes per word, and buffer room: one word outside queue mode
    wire logic [1:0] word_cnt = width_select ? 2'h2 : 2'h1;
    wire logic [4:0] word_bytes = {3'h0, word_cnt};
    wire logic [4:0] capacity = queue_enable ? {1'b0, SFF_DEPTH_CNT} : word_bytes;

    ////////////////////////////////////////////////////////////////////////////
    // Queues

    logic [1:0] tx_push_cnt;
    logic [15:0] tx_push_data;
    logic [1:0] tx_pop_cnt;
    logic [15:0] tx_head;
    logic [3:0] tx_count;
    logic [1:0] rx_push_cnt;
    logic [15:0] rx_push_data;
    logic [1:0] rx_pop_cnt;
    logic [15:0] rx_head;
    logic [3:0] rx_count;

    sff_byte_queue u_tx_queue (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .flush(mode_change),
        .push_cnt(tx_push_cnt),
        .push_data(tx_push_data),
        .pop_cnt(tx_pop_cnt),
        .head(tx_head),
        .count(tx_count)
    );

    sff_byte_queue u_rx_queue (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .flush(mode_change),
        .push_cnt(rx_push_cnt),
        .push_data(rx_push_data),
        .pop_cnt(rx_pop_cnt),
        .head(rx_head),
        .count(rx_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Transmit write path

    logic write_armed;
    logic [7:0] wr_hold_hi;
    logic [7:0] wr_hold_lo;
    logic wr_got_hi;
    logic wr_got_lo;

    // Queue mode needs no status read before a write; buffer mode does
    wire logic write_ok = queue_enable | write_armed;
    wire logic wr_dh_ok = wr_dh & write_ok & width_select;
    wire logic wr_dl_ok = wr_dl & write_ok;
    wire logic next_got_hi = wr_got_hi | wr_dh_ok;
    wire logic next_got_lo = wr_got_lo | wr_dl_ok;
    wire logic wide_word_done = width_select & next_got_hi & next_got_lo;
    wire logic tx_word_in = width_select ? wide_word_done : wr_dl_ok;
    wire logic tx_room = {1'b0, tx_count} + word_bytes <= capacity;
    wire logic tx_take = tx_word_in & tx_room & ~mode_change;

    assign tx_push_cnt = tx_take ? word_cnt : 2'h0;
    assign tx_push_data = width_select
        ? {wr_dh_ok ? bus_req.wdata : wr_hold_hi, wr_dl_ok ? bus_req.wdata : wr_hold_lo}
        : {8'h00, bus_req.wdata};

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            write_armed <= 1'b0;
            wr_hold_hi <= 8'h00;
            wr_hold_lo <= 8'h00;
            wr_got_hi <= 1'b0;
            wr_got_lo <= 1'b0;
        end
        else if (mode_change)
        begin
            write_armed <= 1'b0;
            wr_got_hi <= 1'b0;
            wr_got_lo <= 1'b0;
        end
        else
        begin
            if (rd_status && status.tx_empty_flag)
                write_armed <= 1'b1;
            else if (tx_word_in)
                write_armed <= 1'b0;
            if (wr_dh_ok)
                wr_hold_hi <= bus_req.wdata;
            if (wr_dl_ok)
                wr_hold_lo <= bus_req.wdata;
            // A finished pair is consumed even if the buffer had no room
            wr_got_hi <= next_got_hi & ~tx_word_in;
            wr_got_lo <= next_got_lo & ~tx_word_in & width_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial shifter, clocked by edges found on the synchronised link clock

    logic [15:0] tx_shift;
    logic [15:0] rx_shift;
    logic [4:0] bit_cnt;
    logic shift_loaded;

    wire logic [4:0] word_bits = width_select ? SFF_BITS_WIDE : SFF_BITS_NARROW;
    wire logic [15:0] rx_next = {rx_shift[14:0], mosi_s};
    wire logic [4:0] bit_cnt_inc = bit_cnt + 5'h01;
    wire logic word_done = sck_rise && bit_cnt_inc == word_bits;
    // Next queued word goes to the shifter as soon as the previous one ends
    wire logic load_now = module_enable & ~shift_loaded & bit_cnt == 5'h00
        & {1'b0, tx_count} >= word_bytes & ~mode_change;
    wire logic rx_room = {1'b0, rx_count} + word_bytes <= capacity;

    assign tx_pop_cnt = load_now ? word_cnt : 2'h0;
    // A word arriving into a full buffer is dropped and the old data kept
    assign rx_push_cnt = (word_done & rx_room & module_enable & ~mode_change)
        ? word_cnt : 2'h0;
    assign rx_push_data = width_select ? rx_next : {8'h00, rx_next[7:0]};

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sck_prev <= 1'b0;
            tx_shift <= 16'h0000;
            rx_shift <= 16'h0000;
            bit_cnt <= 5'h00;
            shift_loaded <= 1'b0;
        end
        else
        begin
            sck_prev <= sck_s;
            if (mode_change || sel_n_s)
                bit_cnt <= 5'h00;
            else if (word_done)
                bit_cnt <= 5'h00;
            else if (sck_rise)
                bit_cnt <= bit_cnt_inc;
            if (sck_rise)
                rx_shift <= rx_next;
            if (load_now)
                tx_shift <= width_select ? tx_head : {tx_head[7:0], 8'h00};
            // The closing fall of a word must not shift the next word just loaded
            else if (sck_fall && bit_cnt != 5'h00)
                tx_shift <= {tx_shift[14:0], 1'b0};
            if (mode_change || word_done)
                shift_loaded <= 1'b0;
            else if (load_now)
                shift_loaded <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive read path with coherent byte pair

    logic [15:0] rd_latch;
    logic rd_latch_valid;
    logic rd_latch_hi_first;

    wire logic rd_byte = rd_dh | rd_dl;
    wire logic rx_word_avail = {1'b0, rx_count} >= word_bytes;
    wire logic pair_close = rd_latch_valid & (rd_dh ^ rd_latch_hi_first);
    wire logic snap_now = width_select & rd_byte & ~rd_latch_valid & rx_word_avail;
    wire logic [15:0] wide_src = rd_latch_valid ? rd_latch : rx_head;
    wire logic [7:0] wide_byte = rd_dh ? wide_src[15:8] : wide_src[7:0];
    wire logic wide_has = rd_latch_valid | rx_word_avail;
    wire logic [7:0] narrow_byte = (rd_dl && rx_word_avail) ? rx_head[7:0] : 8'h00;
    wire logic narrow_pop = ~width_select & rd_dl & rx_word_avail;

    // Drain happens on the low byte read, or when the second of a pair is read
    assign rx_pop_cnt = mode_change ? 2'h0
        : (narrow_pop ? 2'h1 : ((width_select & rd_byte & pair_close) ? 2'h2 : 2'h0));

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_latch <= 16'h0000;
            rd_latch_valid <= 1'b0;
            rd_latch_hi_first <= 1'b0;
        end
        else if (mode_change)
            rd_latch_valid <= 1'b0;
        else if (snap_now)
        begin
            rd_latch <= rx_head;
            rd_latch_valid <= 1'b1;
            rd_latch_hi_first <= rd_dh;
        end
        else if (width_select && rd_byte && pair_close)
            rd_latch_valid <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags, derived from fill counts every clock

    sff_status_t next_status;
    wire logic [3:0] rx_mark_bytes = rx_mark ? SFF_RX_MARK1 : SFF_RX_MARK0;
    wire logic [3:0] tx_mark_bytes = tx_mark ? SFF_TX_MARK1 : SFF_TX_MARK0;
    // The loaded shifter is not counted, so empty means the buffer can take another word
    wire logic tx_buf_empty = tx_count == 4'h0;

    assign next_status.rx_full_flag = queue_enable
        ? rx_count == SFF_DEPTH_CNT : rx_word_avail;
    assign next_status.rsvd_match = 1'b0;
    assign next_status.tx_empty_flag = tx_buf_empty;
    assign next_status.rsvd_fault = 1'b0;
    assign next_status.rx_nearly_full_flag = queue_enable
        && rx_count >= rx_mark_bytes;
    // After a flush in queue mode the empty queues raise the empty, nearly-empty and read-empty flags at once
    assign next_status.tx_nearly_empty_flag = queue_enable
        && tx_count <= tx_mark_bytes;
    assign next_status.tx_fifo_full_flag = queue_enable
        && tx_count == SFF_DEPTH_CNT;
    assign next_status.rx_fifo_empty_flag = queue_enable
        && rx_count == 4'h0;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            status <= SFF_STATUS_RESET;
        else
            status <= next_status;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and link outputs

    logic [7:0] next_rd_data;
    wire logic [7:0] ctrl_value = {6'h00, width_select, module_enable};
    wire logic [7:0] c3_value = {2'h0, tx_mark, rx_mark, 3'h0, queue_enable};
    wire logic [7:0] data_value = width_select
        ? (wide_has ? wide_byte : 8'h00) : narrow_byte;

    assign next_rd_data = rd_status ? status
        : rd_byte ? data_value
        : rd_ctrl ? ctrl_value
        : rd_c3 ? c3_value
        : 8'h00;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_data <= 8'h00;
            link_miso_out <= 1'b0;
            link_miso_oe <= 1'b0;
        end
        else
        begin
            rd_data <= bus_req.rd ? next_rd_data : 8'h00;
            link_miso_out <= tx_shift[15];
            link_miso_oe <= module_enable & ~sel_n_s;
        end
    end

    assign tx_empty_flag = status.tx_empty_flag;
    assign rx_full_flag = status.rx_full_flag;

endmodule : sff_top
`default_nettype wire

// file: include/sff_pkg.sv
// Constants, register map and carrier types of the serial queue flag and data port block
// Contract
// - Mark 0: nearly-full at 48 bits or more
// - Mark 1: nearly-full at 32 bits or more
// - Nearly-full flag idle without queue mode
// - Mark 0: nearly-empty at 16 bits or less
// - Mark 1: nearly-empty at 32 bits or less
// - Power-on: nearly-empty and read-empty flags zero
// - Width, queue, enable change flushes queues, flags
// - After flush flags follow queue enable
// - Queue mode: full flag at 8 bytes
// - Read-empty flag; data reads drain the queue
// - Data writes queue transmit; reads return receive
// - Queued data starts right after previous word
// - Buffer-mode data write needs prior status read, else ignored
// - Receive overrun keeps old data, silently
// - 8-bit mode: high byte reads zero, ignores writes
// - 16-bit read snapshots both bytes until pair done
// - 16-bit write queues only after both bytes
// - Queue mode uses 8-byte queues both ways
// - Idle transmitter empties buffer within two cycles
package sff_pkg;

    localparam int SFF_AW = 3;

    // Register offsets
    localparam logic [SFF_AW-1:0] SFF_OFF_STATUS = 3'h0;
    localparam logic [SFF_AW-1:0] SFF_OFF_DH = 3'h1;
    localparam logic [SFF_AW-1:0] SFF_OFF_DL = 3'h2;
    localparam logic [SFF_AW-1:0] SFF_OFF_CTRL = 3'h3;
    localparam logic [SFF_AW-1:0] SFF_OFF_C3 = 3'h4;

    // Control register fields
    localparam int SFF_CTRL_ENABLE_BIT = 0;
    localparam int SFF_CTRL_WIDTH_BIT = 1;
    localparam logic [7:0] SFF_CTRL_RESET = 8'h00;

    // Third control register fields
    localparam int SFF_C3_QUEUE_BIT = 0;
    localparam int SFF_C3_RX_MARK_BIT = 4;
    localparam int SFF_C3_TX_MARK_BIT = 5;
    localparam logic [7:0] SFF_C3_RESET = 8'h00;

    // Queue geometry and watermarks, in bits as specified, converted to bytes
    localparam int SFF_QUEUE_BITS = 64;
    localparam int SFF_DEPTH = SFF_QUEUE_BITS / 8;
    localparam logic [3:0] SFF_DEPTH_CNT = 4'(SFF_DEPTH);
    localparam int SFF_RX_MARK0_BITS = 48;
    localparam int SFF_RX_MARK1_BITS = 32;
    localparam int SFF_TX_MARK0_BITS = 16;
    localparam int SFF_TX_MARK1_BITS = 32;
    localparam logic [3:0] SFF_RX_MARK0 = 4'(SFF_RX_MARK0_BITS / 8);
    localparam logic [3:0] SFF_RX_MARK1 = 4'(SFF_RX_MARK1_BITS / 8);
    localparam logic [3:0] SFF_TX_MARK0 = 4'(SFF_TX_MARK0_BITS / 8);
    localparam logic [3:0] SFF_TX_MARK1 = 4'(SFF_TX_MARK1_BITS / 8);

    // Serial word lengths
    localparam logic [4:0] SFF_BITS_NARROW = 5'h08;
    localparam logic [4:0] SFF_BITS_WIDE = 5'h10;

    typedef struct packed {
        logic [SFF_AW-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sff_bus_req_t;

    // Status byte, most significant field first
    typedef struct packed {
        logic rx_full_flag;
        logic rsvd_match;
        logic tx_empty_flag;
        logic rsvd_fault;
        logic rx_nearly_full_flag;
        logic tx_nearly_empty_flag;
        logic tx_fifo_full_flag;
        logic rx_fifo_empty_flag;
    } sff_status_t;

    localparam sff_status_t SFF_STATUS_RESET = 8'h00;

endpackage : sff_pkg

// file: rtl/sff_byte_queue.sv
// Eight-byte queue moving one or two bytes per clock each way
`timescale 1ns/10ps
`default_nettype none
module sff_byte_queue
    import sff_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic flush,
    input wire logic [1:0] push_cnt,
    input wire logic [15:0] push_data,
    input wire logic [1:0] pop_cnt,
    output logic [15:0] head,
    output logic [3:0] count
);

    logic [7:0] mem [SFF_DEPTH];
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    wire logic [2:0] wr_ptr1 = wr_ptr + 3'h1;
    wire logic [2:0] rd_ptr1 = rd_ptr + 3'h1;

    // Caller keeps push within free room and pop within fill
    assign head = {mem[rd_ptr1], mem[rd_ptr]};

    always_ff @(posedge mclk)
    begin
        if (push_cnt != 2'h0)
            mem[wr_ptr] <= push_data[7:0];
        if (push_cnt == 2'h2)
            mem[wr_ptr1] <= push_data[15:8];
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            count <= 4'h0;
        end
        else if (flush)
        begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            count <= 4'h0;
        end
        else
        begin
            wr_ptr <= wr_ptr + {1'b0, push_cnt};
            rd_ptr <= rd_ptr + {1'b0, pop_cnt};
            count <= count + {2'h0, push_cnt} - {2'h0, pop_cnt};
        end
    end

endmodule : sff_byte_queue
`default_nettype wire

// file: tb/sff_peer.sv
// Remote link master model: mode 0 frames, link clock still between frames
`timescale 1ns/10ps
`default_nettype none
module sff_peer (
    output logic link_sck,
    output logic link_mosi,
    output logic link_sel_n,
    input wire logic miso_out,
    input wire logic miso_oe
);
    logic last_miso;

    initial
    begin
        link_sck = 1'b0;
        link_mosi = 1'b0;
        link_sel_n = 1'b1;
        last_miso = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One frame of nbits, MSB first, 48 ns link period, odd phase to the bus clock
    task automatic frame(input logic [15:0] word, input int nbits, output logic [15:0] got);
        got = 16'h0000;
        // Select moves off the bus clock edge; link clock edges stay 1 ns ahead of it
        #1 link_sel_n = 1'b0;
        #30;
        for (int i = nbits - 1; i >= 0; i--)
        begin
            link_mosi = word[i];
            #24 link_sck = 1'b1;
            // A released line is read back as the inverse of its last level
            last_miso = miso_oe ? miso_out : ~last_miso;
            got = {got[14:0], last_miso};
            #24 link_sck = 1'b0;
        end
        #31 link_sel_n = 1'b1;
        link_mosi = ~link_mosi;
    endtask : frame
endmodule : sff_peer
`default_nettype wire

// file: tb/sff_top_sva.sv
// Concurrent checks on the flag and data port, bound to the top module
`timescale 1ns/10ps
`default_nettype none
module sff_top_sva
    import sff_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire sff_bus_req_t bus_req,
    input wire logic [7:0] rd_data,
    input wire logic link_sck,
    input wire logic link_mosi,
    input wire logic link_sel_n,
    input wire logic link_miso_out,
    input wire logic link_miso_oe,
    input wire logic tx_empty_flag,
    input wire logic rx_full_flag,
    input wire logic queue_enable
);
    logic wide;
    wire logic rd_stat = bus_req.rd && (bus_req.addr == SFF_OFF_STATUS);
    wire logic rd_dh = bus_req.rd && (bus_req.addr == SFF_OFF_DH);
    wire logic c3_wr = bus_req.wr && (bus_req.addr == SFF_OFF_C3);
    wire logic q_bit = bus_req.wdata[SFF_C3_QUEUE_BIT];

    // Shadow of the width bit, since the mode is not visible at the ports
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            wide <= SFF_CTRL_RESET[SFF_CTRL_WIDTH_BIT];
        else if (bus_req.wr && (bus_req.addr == SFF_OFF_CTRL))
            wide <= bus_req.wdata[SFF_CTRL_WIDTH_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_quiet;
        !bus_req.rd && !bus_req.wr;
    endsequence
    sequence s_queue_on;
        c3_wr && q_bit && !queue_enable;
    endsequence

    property p_rd_idle; !bus_req.rd |=> rd_data == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
    property p_dh_zero; rd_dh && !wide |=> rd_data == 8'h00; endproperty
    a_dh_zero: assert property (p_dh_zero) else $error("high byte not zero");
    property p_status;
        rd_stat |=> rd_data[7] == $past(rx_full_flag) && rd_data[5] == $past(tx_empty_flag)
            && rd_data[6] == 1'b0 && rd_data[4] == 1'b0;
    endproperty
    a_status: assert property (p_status) else $error("status byte mismatch");
    property p_flags_off; rd_stat && !queue_enable && !$past(queue_enable) |=> rd_data[3:0] == 4'h0;
    endproperty
    a_flags_off: assert property (p_flags_off) else $error("queue flags active");
    property p_queue_wr; c3_wr |=> queue_enable == $past(q_bit); endproperty
    a_queue_wr: assert property (p_queue_wr) else $error("queue bit not taken");
    property p_queue_hold; !c3_wr |=> $stable(queue_enable); endproperty
    a_queue_hold: assert property (p_queue_hold) else $error("queue bit moved");
    property p_flush; s_queue_on |-> ##2 tx_empty_flag && !rx_full_flag; endproperty
    a_flush: assert property (p_flush) else $error("queues not flushed");
    // A read one cycle before the window still drains the flag, so it is excluded too
    property p_rx_keep;
        s_quiet ##1 (rx_full_flag ##0 s_quiet) ##1 s_quiet |-> ##1 rx_full_flag;
    endproperty
    a_rx_keep: assert property (p_rx_keep) else $error("receive data lost");
    property p_oe_off; link_sel_n [*4] |-> !link_miso_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("data out driven unselected");
endmodule : sff_top_sva

bind sff_top sff_top_sva u_sva (.mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req),
    .rd_data(rd_data), .link_sck(link_sck), .link_mosi(link_mosi), .link_sel_n(link_sel_n),
    .link_miso_out(link_miso_out), .link_miso_oe(link_miso_oe), .tx_empty_flag(tx_empty_flag),
    .rx_full_flag(rx_full_flag), .queue_enable(queue_enable));
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the flag and data port with a remote link master
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import sff_pkg::*;
    logic mclk;
    logic sys_rst;
    sff_bus_req_t bus_req;
    logic [7:0] rd_data;
    logic link_sck;
    logic link_mosi;
    logic link_sel_n;
    logic miso_out;
    logic miso_oe;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;

    sff_top uut (.mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req), .rd_data(rd_data),
        .link_sck(link_sck), .link_mosi(link_mosi), .link_sel_n(link_sel_n),
        .link_miso_out(miso_out), .link_miso_oe(miso_oe), .tx_empty_flag(),
        .rx_full_flag(), .queue_enable());
    sff_peer peer (.link_sck(link_sck), .link_mosi(link_mosi), .link_sel_n(link_sel_n),
        .miso_out(miso_out), .miso_oe(miso_oe));

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic results;
        if (bad_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask : idle

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask : wr

    // Read data are only valid in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1;
        check(16'(rd_data), 16'(exp));
    endtask : rd

    task automatic xfer(input logic [15:0] word, input int n, input logic [15:0] exp);
        logic [15:0] got;
        peer.frame(word, n, got);
        check(got, exp);
        idle(4);
    endtask : xfer

    // Expected queue-mode status byte from fill counts in bytes and the mark select
    function automatic logic [7:0] qstat(input int tc, input int rc, input logic m);
        int txm;
        int rxm;
        txm = m ? SFF_TX_MARK1 : SFF_TX_MARK0;
        rxm = m ? SFF_RX_MARK1 : SFF_RX_MARK0;
        return {rc == SFF_DEPTH, 1'b0, tc == 0, 1'b0, rc >= rxm, tc <= txm, tc == SFF_DEPTH, rc == 0};
    endfunction : qstat

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        bus_req = '0;
        sys_rst = 1'b1;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(SFF_OFF_STATUS, 8'h20);
        rd(3'h7, 8'h00);
        wr(3'h6, 8'hff);
        wr(SFF_OFF_CTRL, 8'h01);
        wr(SFF_OFF_DL, 8'h77);
        idle(3);
        rd(SFF_OFF_STATUS, 8'h20);
        wr(SFF_OFF_DL, 8'ha5);
        idle(1);
        rd(SFF_OFF_STATUS, 8'h20);
        wr(SFF_OFF_DL, 8'h3c);
        idle(2);
        rd(SFF_OFF_STATUS, 8'h00);
        wr(SFF_OFF_DL, 8'hff);
        xfer(16'h0011, 8, 16'h00a5);
        xfer(16'h0022, 8, 16'h003c);
        rd(SFF_OFF_STATUS, 8'ha0);
        rd(SFF_OFF_DH, 8'h00);
        rd(SFF_OFF_DL, 8'h11);
        rd(SFF_OFF_STATUS, 8'h20);
        // Wide words, bytes written low first
        wr(SFF_OFF_CTRL, 8'h03);
        rd(SFF_OFF_STATUS, 8'h20);
        wr(SFF_OFF_DL, 8'hef);
        wr(SFF_OFF_DH, 8'hbe);
        xfer(16'h1234, 16, 16'hbeef);
        rd(SFF_OFF_DL, 8'h34);
        rd(SFF_OFF_DL, 8'h34);
        rd(SFF_OFF_DH, 8'h12);
        rd(SFF_OFF_STATUS, 8'h20);
        // Queue mode: nine bytes fit (shifter plus eight), the tenth is refused
        wr(SFF_OFF_CTRL, 8'h01);
        wr(SFF_OFF_C3, 8'h01);
        rd(SFF_OFF_STATUS, 8'h25);
        wr(SFF_OFF_DH, 8'h99);
        for (int k = 1; k <= 10; k++)
        begin
            wr(SFF_OFF_DL, 8'(k));
            idle(3);
            rd(SFF_OFF_STATUS, qstat((k > 9) ? 8 : k - 1, 0, 1'b0));
        end
        for (int j = 0; j <= 8; j++)
        begin
            xfer(16'(8'h40 + j), 8, 16'(j + 1));
            rd(SFF_OFF_STATUS, qstat((j < 7) ? 7 - j : 0, (j < 8) ? j + 1 : 8, 1'b0));
            wr(SFF_OFF_C3, 8'h31);
            rd(SFF_OFF_STATUS, qstat((j < 7) ? 7 - j : 0, (j < 8) ? j + 1 : 8, 1'b1));
            wr(SFF_OFF_C3, 8'h01);
        end
        for (int j = 0; j <= 8; j++)
        begin
            rd(SFF_OFF_DL, (j < 8) ? 8'(8'h40 + j) : 8'h00);
            rd(SFF_OFF_STATUS, qstat(0, (j < 8) ? 7 - j : 0, 1'b0));
        end
        results();
    end
endmodule : tb_top
`default_nettype wire
